//--- rtl/dct_pkg.sv
// Shared constants, types and helpers for the DDR2 command timing block
package dct_pkg;

    // ====================================================
    // Geometry
    localparam int NUM_BANKS = 4;
    localparam int BA_W = 2;
    localparam int PIN_W = 10;

    // ====================================================
    // Latencies counted in link clocks (CK) or half clocks
    localparam logic [3:0] CL_CK = 4'h3;
    // Row active minimum in CK; plain default, tune per speed grade
    localparam logic [3:0] T_RAS_CK = 4'h6;
    localparam int ODT_ON_HALF = 4;
    localparam int ODT_OFF_HALF = 5;

    // ====================================================
    // Reset values
    localparam logic [PIN_W-1:0] PIN_RST = 10'h000;
    localparam logic [3:0] CNT_RST = 4'h0;

    // ====================================================
    // Decoded command and power state
    typedef enum logic [2:0] {
        CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS
    } dct_cmd_t;

    typedef enum logic [1:0] {
        PWR_ACTIVE, PWR_SELF_REF, PWR_PD_PRE, PWR_PD_ACT
    } dct_pwr_t;

    // Command truth table on the registered control pins
    function automatic dct_cmd_t dct_decode(input logic [3:0] c);
        dct_cmd_t r;
        r = CMD_NOP;
        if (c[3]) begin
            r = CMD_NOP;
        end else if (c[2:0] == 3'h3) begin
            r = CMD_ACT;
        end else if (c[2:0] == 3'h5) begin
            r = CMD_RD;
        end else if (c[2:0] == 3'h4) begin
            r = CMD_WR;
        end else if (c[2:0] == 3'h2) begin
            r = CMD_PRE;
        end else if (c[2:0] == 3'h1) begin
            r = CMD_REF;
        end else if (c[2:0] == 3'h0) begin
            r = CMD_MRS;
        end
        return r;
    endfunction : dct_decode

endpackage : dct_pkg

//--- rtl/dct_bank_if.sv
// Per-bank request and status bundle between top and bank tracker
`timescale 1ns/1ps
interface dct_bank_if;
    logic tick;
    logic act;
    logic pre_now;
    logic ap_req;
    logic row_open;
    logic pre_fire;

    modport ctl (
        output tick, act, pre_now, ap_req,
        input row_open, pre_fire
    );
    modport bank (
        input tick, act, pre_now, ap_req,
        output row_open, pre_fire
    );
endinterface : dct_bank_if

//--- rtl/dct_bank.sv
// One bank: open row, row-active timer and auto-precharge lockout
`timescale 1ns/1ps
module dct_bank
    import dct_pkg::*;
(
    // Clock and control
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ce,
    // Requests and status
    dct_bank_if.bank bif
);

    logic row_open_ff, nxt_row_open;
    logic ap_pend_ff, nxt_ap_pend;
    logic pre_fire_ff, nxt_pre_fire;
    logic by_ap_ff, nxt_by_ap;
    logic [3:0] ras_cnt_ff, nxt_ras_cnt;
    logic ras_done;

    assign ras_done = (ras_cnt_ff == T_RAS_CK);
    assign bif.row_open = row_open_ff;
    assign bif.pre_fire = pre_fire_ff;

    // ====================================================
    // Row state and lockout
    always_comb begin
        nxt_row_open = row_open_ff;
        nxt_ap_pend = ap_pend_ff;
        nxt_ras_cnt = ras_cnt_ff;
        nxt_pre_fire = 1'b0;
        nxt_by_ap = by_ap_ff;
        if (bif.tick) begin
            // Timer saturates so a long-open row stays unlocked
            if (row_open_ff && !ras_done) begin
                nxt_ras_cnt = ras_cnt_ff + 4'h1;
            end
            if (bif.act) begin
                nxt_row_open = 1'b1;
                nxt_ras_cnt = CNT_RST;
                nxt_ap_pend = 1'b0;
            end else if (row_open_ff && bif.pre_now) begin
                nxt_row_open = 1'b0;
                nxt_ap_pend = 1'b0;
                nxt_pre_fire = 1'b1;
                nxt_by_ap = 1'b0;
            end else if (row_open_ff && (bif.ap_req || ap_pend_ff)) begin
                // Early auto precharge is taken and parked, not refused
                if (ras_done) begin
                    nxt_row_open = 1'b0;
                    nxt_ap_pend = 1'b0;
                    nxt_pre_fire = 1'b1;
                    nxt_by_ap = 1'b1;
                end else begin
                    nxt_ap_pend = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            row_open_ff <= 1'b0;
            ap_pend_ff <= 1'b0;
            pre_fire_ff <= 1'b0;
            by_ap_ff <= 1'b0;
            ras_cnt_ff <= CNT_RST;
        end else if (ce) begin
            row_open_ff <= nxt_row_open;
            ap_pend_ff <= nxt_ap_pend;
            pre_fire_ff <= nxt_pre_fire;
            by_ap_ff <= nxt_by_ap;
            ras_cnt_ff <= nxt_ras_cnt;
        end
    end

    // ====================================================
    // Checks
    property p_ap_after_ras;
        @(posedge ref_clk) disable iff (reset)
        (pre_fire_ff && by_ap_ff) |-> (ras_cnt_ff == T_RAS_CK);
    endproperty
    a_ap_after_ras: assert property (p_ap_after_ras)
        else $error("internal precharge before row active time");

    property p_ap_parked;
        @(posedge ref_clk) disable iff (reset)
        (ce && bif.tick && bif.ap_req && row_open_ff && !ras_done
            && !bif.act && !bif.pre_now) |=> (ap_pend_ff && row_open_ff);
    endproperty
    a_ap_parked: assert property (p_ap_parked)
        else $error("early auto precharge request was lost");

    property p_close_fires;
        @(posedge ref_clk) disable iff (reset)
        $fell(row_open_ff) |-> pre_fire_ff;
    endproperty
    a_close_fires: assert property (p_close_fires)
        else $error("row closed without internal precharge");

    c_ap_lockout: cover property (@(posedge ref_clk) disable iff (reset)
        pre_fire_ff && by_ap_ff);

endmodule : dct_bank

//--- rtl/dct_top.sv
// DDR2 device-side command registration and timing behaviour
// How it works
// - Read or write with auto precharge is accepted before row time.
// - Internal precharge from auto precharge waits until the bank's row active time passed.
// - First read data appears CAS latency clocks after the read.
// - Termination turns off 2.5 clocks after ODT is registered low.
`timescale 1ns/1ps
module dct_top
    import dct_pkg::*;
(
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ce,
    // Link pins from the memory controller
    input wire logic ck_pin,
    input wire logic cke_pin,
    input wire logic cs_n_pin,
    input wire logic ras_n_pin,
    input wire logic cas_n_pin,
    input wire logic we_n_pin,
    input wire logic [BA_W-1:0] ba_pin,
    input wire logic a10_pin,
    input wire logic odt_pin,
    // Device state
    output logic rd_start,
    output logic odt_on,
    output logic cke_level,
    output logic freq_ok,
    output logic [NUM_BANKS-1:0] bank_open,
    output logic [NUM_BANKS-1:0] int_pre
);

    logic [PIN_W-1:0] pin_raw, pin_s1_ff, pin_s2_ff;
    logic ck_prev_ff;
    logic ck_s, cke_s, odt_s, a10_s;
    logic [3:0] ctl_s;
    logic [BA_W-1:0] ba_s;
    logic rise, fall, half;
    dct_cmd_t cmd;
    logic cmd_ok;

    // ====================================================
    // Pin synchroniser and link clock edges
    assign pin_raw = {ck_pin, cke_pin, cs_n_pin, ras_n_pin, cas_n_pin,
        we_n_pin, ba_pin, a10_pin, odt_pin};
    assign ck_s = pin_s2_ff[9];
    assign cke_s = pin_s2_ff[8];
    assign ctl_s = pin_s2_ff[7:4];
    assign ba_s = pin_s2_ff[3:2];
    assign a10_s = pin_s2_ff[1];
    assign odt_s = pin_s2_ff[0];

    // Two stages on every pin so the command word is skew-matched
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pin_s1_ff <= PIN_RST;
            pin_s2_ff <= PIN_RST;
            ck_prev_ff <= 1'b0;
        end else if (ce) begin
            pin_s1_ff <= pin_raw;
            pin_s2_ff <= pin_s1_ff;
            ck_prev_ff <= ck_s;
        end
    end

    assign rise = ck_s && !ck_prev_ff;
    assign fall = !ck_s && ck_prev_ff;
    assign half = rise || fall;

    // ====================================================
    // Command registration, gated by registered CKE
    logic cke_ff, nxt_cke;
    dct_pwr_t pwr_ff, nxt_pwr;
    logic freq_ok_ff, nxt_freq_ok;
    logic any_open;

    assign cmd = dct_decode(ctl_s);
    assign cmd_ok = rise && cke_ff && cke_s;
    assign any_open = |bank_open;

    always_comb begin
        nxt_cke = cke_ff;
        nxt_pwr = pwr_ff;
        if (rise) begin
            nxt_cke = cke_s;
            if (cke_ff && !cke_s) begin
                // Refresh with CKE falling enters self refresh
                if (cmd == CMD_REF) begin
                    nxt_pwr = PWR_SELF_REF;
                end else if (any_open) begin
                    nxt_pwr = PWR_PD_ACT;
                end else begin
                    nxt_pwr = PWR_PD_PRE;
                end
            end else if (!cke_ff && cke_s) begin
                nxt_pwr = PWR_ACTIVE;
            end
        end
        case (nxt_pwr)
            PWR_SELF_REF: nxt_freq_ok = 1'b1;
            PWR_PD_PRE: nxt_freq_ok = 1'b1;
            default: nxt_freq_ok = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            // CKE reads low at reset: the system reset condition
            cke_ff <= 1'b0;
            pwr_ff <= PWR_SELF_REF;
            freq_ok_ff <= 1'b1;
        end else if (ce) begin
            cke_ff <= nxt_cke;
            pwr_ff <= nxt_pwr;
            freq_ok_ff <= nxt_freq_ok;
        end
    end

    assign cke_level = cke_ff;
    assign freq_ok = freq_ok_ff;

    // ====================================================
    // Bank trackers
    dct_bank_if bif[NUM_BANKS] ();

    for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
        logic hit;
        assign hit = (ba_s == BA_W'(g));
        assign bif[g].tick = rise;
        assign bif[g].act = cmd_ok && (cmd == CMD_ACT) && hit;
        // Precharge all reaches every bank at once
        assign bif[g].pre_now = cmd_ok && (cmd == CMD_PRE) && (a10_s || hit);
        assign bif[g].ap_req = cmd_ok && a10_s && hit
            && ((cmd == CMD_RD) || (cmd == CMD_WR));
        assign bank_open[g] = bif[g].row_open;
        assign int_pre[g] = bif[g].pre_fire;
        dct_bank u_bank (
            .ref_clk(ref_clk),
            .reset(reset),
            .ce(ce),
            .bif(bif[g])
        );
    end

    // ====================================================
    // Read latency pipe, one stage per link clock
    logic [CL_CK-1:0] rd_pipe_ff, nxt_rd_pipe;
    logic rd_start_ff, nxt_rd_start;

    always_comb begin
        nxt_rd_pipe = rd_pipe_ff;
        nxt_rd_start = 1'b0;
        if (rise) begin
            nxt_rd_pipe = {rd_pipe_ff[CL_CK-2:0], cmd_ok && (cmd == CMD_RD)};
            nxt_rd_start = rd_pipe_ff[CL_CK-1];
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rd_pipe_ff <= '0;
            rd_start_ff <= 1'b0;
        end else if (ce) begin
            rd_pipe_ff <= nxt_rd_pipe;
            rd_start_ff <= nxt_rd_start;
        end
    end

    assign rd_start = rd_start_ff;

    // ====================================================
    // Termination delays counted in half link clocks
    // Half-clock steps follow the real duty cycle of the link clock
    logic odt_reg_ff, nxt_odt_reg;
    logic [ODT_OFF_HALF-1:0] odt_hist_ff, nxt_odt_hist;
    logic odt_on_ff, nxt_odt_on;

    always_comb begin
        nxt_odt_reg = odt_reg_ff;
        nxt_odt_hist = odt_hist_ff;
        nxt_odt_on = odt_on_ff;
        if (rise) begin
            nxt_odt_reg = odt_s;
        end
        if (half) begin
            nxt_odt_hist = {odt_hist_ff[ODT_OFF_HALF-2:0], nxt_odt_reg};
            // Turn-on after 2 clocks, turn-off after 2.5
            if (odt_on_ff) begin
                nxt_odt_on = odt_hist_ff[ODT_OFF_HALF-1];
            end else begin
                nxt_odt_on = odt_hist_ff[ODT_ON_HALF-1];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            odt_reg_ff <= 1'b0;
            odt_hist_ff <= '0;
            odt_on_ff <= 1'b0;
        end else if (ce) begin
            odt_reg_ff <= nxt_odt_reg;
            odt_hist_ff <= nxt_odt_hist;
            odt_on_ff <= nxt_odt_on;
        end
    end

    assign odt_on = odt_on_ff;

    // ====================================================
    // Checks
    property p_rd_enter;
        @(posedge ref_clk) disable iff (reset)
        (ce && cmd_ok && cmd == CMD_RD) |=> rd_pipe_ff[0];
    endproperty
    a_rd_enter: assert property (p_rd_enter)
        else $error("read command not entered in latency pipe");

    property p_rd_out;
        @(posedge ref_clk) disable iff (reset)
        rd_start_ff |-> ($past(rise) && $past(rd_pipe_ff[CL_CK-1]));
    endproperty
    a_rd_out: assert property (p_rd_out)
        else $error("read data start not at CAS latency");

    property p_odt_off;
        @(posedge ref_clk) disable iff (reset)
        $fell(odt_on_ff) |-> ($past(half)
            && !$past(odt_hist_ff[ODT_OFF_HALF-1]));
    endproperty
    a_odt_off: assert property (p_odt_off)
        else $error("termination dropped before 2.5 clocks");

    property p_odt_hold;
        @(posedge ref_clk) disable iff (reset)
        (odt_on_ff && odt_hist_ff[ODT_OFF_HALF-1]) |=> odt_on_ff;
    endproperty
    a_odt_hold: assert property (p_odt_hold)
        else $error("termination released while still requested");

    property p_freq_ok;
        @(posedge ref_clk) disable iff (reset)
        freq_ok_ff |-> (!cke_ff && !(pwr_ff == PWR_PD_ACT));
    endproperty
    a_freq_ok: assert property (p_freq_ok)
        else $error("frequency change window with CKE high");

    c_read: cover property (@(posedge ref_clk) disable iff (reset)
        rd_start_ff);
    c_odt: cover property (@(posedge ref_clk) disable iff (reset)
        $fell(odt_on_ff));
    c_self_ref: cover property (@(posedge ref_clk) disable iff (reset)
        pwr_ff == PWR_SELF_REF && $past(pwr_ff) == PWR_ACTIVE);

endmodule : dct_top

//--- verif/dct_ctl.sv
// Memory controller model driving the DDR2 command link
`timescale 1ns/1ps
module dct_ctl
    import dct_pkg::*;
(
    // Link clock and clock enable
    output logic ck_pin,
    output logic cke_pin,
    // Command and address pins
    output logic cs_n_pin,
    output logic ras_n_pin,
    output logic cas_n_pin,
    output logic we_n_pin,
    output logic [BA_W-1:0] ba_pin,
    output logic a10_pin,
    // Termination request
    output logic odt_pin
);
    int rises = 0;
    int hedges = 0;

    // ==========================================
    // Free-running CK, phase unrelated to ref_clk
    initial begin
        ck_pin = 1'b0;
        #37;
        forever #200 ck_pin = ~ck_pin;
    end

    // Rise and half-edge counts give the bench a CK time base
    always @(posedge ck_pin) rises <= rises + 1;
    always @(ck_pin) hedges <= hedges + 1;

    // CKE low from time zero so the reset state sees it low
    initial begin
        cke_pin = 1'b0;
        cs_n_pin = 1'b1;
        {ras_n_pin, cas_n_pin, we_n_pin} = 3'h7;
        ba_pin = 2'h0;
        a10_pin = 1'b0;
        odt_pin = 1'b0;
    end

    // ==========================================
    // Command on the next rise; pins held until the following fall
    task automatic send(input logic [3:0] c, input logic [BA_W-1:0] b,
                        input logic a, output int at);
        @(negedge ck_pin);
        {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} = c;
        ba_pin = b;
        a10_pin = a;
        @(posedge ck_pin);
        #1 at = rises;
    endtask : send

    // No strobe pin and no write issued, so no write recovery
    // Deselect; released lines flip so a stale command is never seen
    task automatic idle();
        @(negedge ck_pin);
        cs_n_pin = 1'b1;
        {ras_n_pin, cas_n_pin, we_n_pin} = ~{ras_n_pin, cas_n_pin, we_n_pin};
        ba_pin = ~ba_pin;
        a10_pin = ~a10_pin;
    endtask : idle

    // New CKE level held for three registered rises
    task automatic set_cke(input logic v);
        @(negedge ck_pin);
        cke_pin = v;
        repeat (3) @(posedge ck_pin);
    endtask : set_cke

    // Self refresh entry: refresh with CKE dropping at the same rise
    // CKE drops at the same negedge as the command, so one rise sees both
    task automatic sref_in();
        @(negedge ck_pin);
        cke_pin = 1'b0;
        // Only refresh of the run, well inside the maximum gap
        {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} = 4'h1;
        ba_pin = 2'h0;
        a10_pin = 1'b0;
        @(posedge ck_pin);
        idle();
        repeat (2) @(posedge ck_pin);
    endtask : sref_in

    // Self refresh exit; no read for 200 clocks afterwards
    task automatic sref_out();
        set_cke(1'b1);
        repeat (200) @(posedge ck_pin);
    endtask : sref_out

    // Termination request registered at the next rise
    task automatic set_odt(input logic v, output int h);
        @(negedge ck_pin);
        odt_pin = v;
        @(posedge ck_pin);
        #1 h = hedges;
    endtask : set_odt

endmodule : dct_ctl

//--- verif/tb_dct_top.sv
// Self-checking bench for the DDR2 command timing block
`timescale 1ns/1ps
module tb_dct_top
    import dct_pkg::*;
;
    localparam logic [3:0] C_ACT = 4'h3;
    localparam logic [3:0] C_RD = 4'h5;
    localparam logic [3:0] C_PRE = 4'h2;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    wire ck_pin, cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin;
    wire a10_pin, odt_pin;
    wire [BA_W-1:0] ba_pin;
    logic rd_start, odt_on, cke_level, freq_ok, odt_prev = 1'b0;
    logic [NUM_BANKS-1:0] bank_open, int_pre, ip_bank;
    int fail_count = 0, checked = 0;
    int rd_cnt = 0, rd_at = 0, ip_cnt = 0, ip_at = 0, odt_at = 0;

    // ==========================================
    // Clock, device and controller model
    always #25 ref_clk = ~ref_clk;

    dct_top i_dct_top (.ref_clk(ref_clk), .reset(reset), .ce(ce),
        .ck_pin(ck_pin), .cke_pin(cke_pin), .cs_n_pin(cs_n_pin),
        .ras_n_pin(ras_n_pin), .cas_n_pin(cas_n_pin), .we_n_pin(we_n_pin),
        .ba_pin(ba_pin), .a10_pin(a10_pin), .odt_pin(odt_pin),
        .rd_start(rd_start), .odt_on(odt_on), .cke_level(cke_level),
        .freq_ok(freq_ok), .bank_open(bank_open), .int_pre(int_pre));

    dct_ctl i_dct_ctl (.ck_pin(ck_pin), .cke_pin(cke_pin),
        .cs_n_pin(cs_n_pin), .ras_n_pin(ras_n_pin), .cas_n_pin(cas_n_pin),
        .we_n_pin(we_n_pin), .ba_pin(ba_pin), .a10_pin(a10_pin),
        .odt_pin(odt_pin));

    // Pulse positions in CK terms; sampled well clear of CK edges
    always @(negedge ref_clk) begin
        if (rd_start === 1'b1) begin
            rd_cnt++;
            rd_at = i_dct_ctl.rises;
        end
        if (int_pre !== 4'h0) begin
            ip_cnt++;
            ip_at = i_dct_ctl.rises;
            ip_bank = int_pre;
        end
        if (odt_on !== odt_prev) odt_at = i_dct_ctl.hedges;
        odt_prev = odt_on;
    end

    // ==========================================
    // Compare, wait and closing tasks
    task automatic chk_vec(input logic [3:0] got, input logic [3:0] exp,
                           input string msg);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk_vec

    task automatic chk_num(input int got, input int exp, input string msg);
        checked++;
        if (got != exp) begin
            fail_count++;
            $display("[ERR] %0t %s got %0d exp %0d", $time, msg, got, exp);
        end
    endtask : chk_num

    // Past n CK rises, then settle before the next CK rise
    task automatic ck_wait(input int n);
        repeat (n) @(posedge ck_pin);
        repeat (6) @(negedge ref_clk);
    endtask : ck_wait

    task automatic final_report();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    // ==========================================
    // Scenarios
    // Reset state, activate refused while CKE low, then CKE up
    task automatic t_reset();
        int a;
        chk_vec({rd_start, odt_on, cke_level, freq_ok}, 4'h1, "reset outs");
        chk_vec(bank_open, 4'h0, "reset banks");
        i_dct_ctl.send(C_ACT, 2'h3, 1'b0, a);
        i_dct_ctl.idle();
        ck_wait(2);
        chk_vec(bank_open, 4'h0, "act with cke low");
        i_dct_ctl.set_cke(1'b1);
        ck_wait(0);
        chk_vec({2'h0, cke_level, freq_ok}, 4'h2, "cke up");
    endtask : t_reset

    // Back-to-back reads; each pulse exactly CL rises later
    task automatic t_read();
        int a, r1, r2;
        i_dct_ctl.send(C_ACT, 2'h1, 1'b0, a);
        i_dct_ctl.send(C_RD, 2'h1, 1'b0, r1);
        i_dct_ctl.send(C_RD, 2'h1, 1'b0, r2);
        i_dct_ctl.idle();
        ck_wait(int'(CL_CK) - 2);
        chk_num(rd_cnt, 0, "read too early");
        ck_wait(1);
        chk_num(rd_at - r1, int'(CL_CK), "first read latency");
        ck_wait(1);
        chk_num(rd_cnt, 2, "read pulses");
        chk_num(rd_at - r2, int'(CL_CK), "second read latency");
        chk_vec(bank_open, 4'h2, "bank1 open");
    endtask : t_read

    // Read with auto precharge right after activate: lockout holds
    task automatic t_autopre();
        int a0, r;
        i_dct_ctl.send(C_ACT, 2'h0, 1'b0, a0);
        i_dct_ctl.send(C_RD, 2'h0, 1'b1, r);
        i_dct_ctl.idle();
        ck_wait(int'(T_RAS_CK) - 1);
        chk_vec(bank_open, 4'h3, "open through row time");
        chk_num(ip_cnt, 0, "precharge too early");
        ck_wait(1);
        chk_num(ip_at - a0, int'(T_RAS_CK) + 1, "internal precharge");
        chk_vec(ip_bank, 4'h1, "precharged bank");
        chk_vec(bank_open, 4'h2, "bank0 closed");
    endtask : t_autopre

    // Single-bank and all-bank precharge; every close pulses int_pre once
    task automatic t_pre();
        int a;
        i_dct_ctl.send(C_PRE, 2'h1, 1'b0, a);
        i_dct_ctl.send(C_ACT, 2'h2, 1'b0, a);
        i_dct_ctl.send(C_ACT, 2'h3, 1'b0, a);
        i_dct_ctl.idle();
        ck_wait(1);
        chk_vec(bank_open, 4'hC, "single precharge");
        i_dct_ctl.send(C_PRE, 2'h0, 1'b1, a);
        i_dct_ctl.idle();
        ck_wait(1);
        chk_vec(bank_open, 4'h0, "precharge all");
        chk_num(ip_cnt, 3, "close pulses");
    endtask : t_pre

    // Termination on after 2 CK, off after 2.5 CK
    task automatic t_odt();
        int h;
        i_dct_ctl.set_odt(1'b1, h);
        ck_wait(3);
        chk_num(odt_at - h, 4, "odt on delay");
        chk_vec({3'h0, odt_on}, 4'h1, "odt on");
        i_dct_ctl.set_odt(1'b0, h);
        ck_wait(3);
        chk_num(odt_at - h, 5, "odt off delay");
        chk_vec({3'h0, odt_on}, 4'h0, "odt off");
    endtask : t_odt

    // Frequency change window: active vs precharge power-down, self ref
    task automatic t_power();
        int a;
        i_dct_ctl.send(C_ACT, 2'h0, 1'b0, a);
        i_dct_ctl.idle();
        i_dct_ctl.set_cke(1'b0);
        ck_wait(0);
        chk_vec({3'h0, freq_ok}, 4'h0, "active power-down");
        i_dct_ctl.set_cke(1'b1);
        i_dct_ctl.send(C_PRE, 2'h0, 1'b0, a);
        i_dct_ctl.idle();
        i_dct_ctl.set_cke(1'b0);
        ck_wait(0);
        chk_vec({3'h0, freq_ok}, 4'h1, "precharge power-down");
        i_dct_ctl.set_cke(1'b1);
        ck_wait(0);
        chk_vec({3'h0, freq_ok}, 4'h0, "power-down exit");
        i_dct_ctl.sref_in();
        ck_wait(0);
        chk_vec({3'h0, freq_ok}, 4'h1, "self refresh");
        i_dct_ctl.sref_out();
        ck_wait(0);
        chk_vec({3'h0, freq_ok}, 4'h0, "self refresh exit");
    endtask : t_power

    // ==========================================
    // Main sequence and hang guard
    initial begin
        repeat (3) @(negedge ref_clk);
        reset = 1'b0;
        repeat (2) @(negedge ref_clk);
        t_reset();
        t_read();
        t_autopre();
        t_pre();
        t_odt();
        t_power();
        final_report();
    end

    initial begin
        repeat (100000) @(posedge ref_clk);
        fail_count++;
        $display("[ERR] %0t run timed out", $time);
        final_report();
    end

endmodule : tb_dct_top
